/* dv/pic_checker.sv */
// Purpose: port assertions for pic_top
// Assumes: one clock, synchronous reset
// Notes: bound to the top module below
`timescale 1ns/1ps
`default_nettype none
module pic_checker
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire logic IRQ_ACK,
   input wire logic IRQ_REQ,
   input wire logic [3:0] IRQ_VECTOR,
   input wire logic [3:0] RESET_VECTOR
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   property p_rvec; RESET_VECTOR == 4'h0; endproperty
   a_rvec: assert property (p_rvec) else $error("reset vector moved");
   property p_hi; $past(RD) |-> RDATA[7:4] == 4'h0; endproperty
   a_hi: assert property (p_hi) else $error("high read bits set");
   property p_mid; $past(RD) && $past(ADDR) != 8'h10 |-> RDATA[7:2] == 6'h00; endproperty
   a_mid: assert property (p_mid) else $error("reserved bits set");
   property p_msk; WR && ADDR == 8'h10 ##1 RD && ADDR == 8'h10
      |=> RDATA == ($past(WDATA, 2) & 8'h0f); endproperty
   a_msk: assert property (p_msk) else $error("mask readback wrong");
   property p_sns; WR && ADDR == 8'h15 ##1 RD && ADDR == 8'h15
      |=> RDATA == ($past(WDATA, 2) & 8'h03); endproperty
   a_sns: assert property (p_sns) else $error("sense readback wrong");
   property p_gie; !GLOBAL_IRQ_ENABLE [*2] |=> !IRQ_REQ; endproperty
   a_gie: assert property (p_gie) else $error("request while disabled");
   property p_ack; IRQ_ACK && IRQ_REQ |=> !IRQ_REQ [*2]; endproperty
   a_ack: assert property (p_ack) else $error("request kept after entry");
   property p_vec; IRQ_REQ |-> IRQ_VECTOR inside {[4'h1:4'ha]}; endproperty
   a_vec: assert property (p_vec) else $error("vector out of table");
endmodule : pic_checker
bind pic_top pic_checker u_pic_checker (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
   .IRQ_ACK(IRQ_ACK), .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR),
   .RESET_VECTOR(RESET_VECTOR));
`default_nettype wire

/* dv/pic_core_model.sv */
// Purpose: core side that takes requests
// Assumes: one-cycle entry ack
// Notes: delay lets the bench answer slowly
`timescale 1ns/1ps
`default_nettype none
module pic_core_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic take,
   input wire logic [3:0] delay,
   input wire logic irq_req,
   input wire logic [3:0] irq_vector,
   output logic irq_ack,
   output logic [3:0] served_vec
);
   logic [3:0] wait_q;
   // ack pulse marks routine entry, never two in a row
   always_ff @(posedge clk)
   begin
      if (rst || !irq_req || irq_ack || !take)
      begin
         irq_ack <= 1'b0;
         wait_q <= 4'h0;
      end
      else if (wait_q == delay)
      begin
         irq_ack <= 1'b1;
         served_vec <= irq_vector;
      end
      else
         wait_q <= wait_q + 4'h1;
   end
endmodule : pic_core_model
`default_nettype wire

/* dv/pic_top_tb.sv */
// Purpose: self-checking bench for pic_top
// Assumes: pic_core_model plays the core
// Notes: fixed seed, so runs repeat
`timescale 1ns/1ps
`default_nettype none
module pic_top_tb;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] ADDR = 8'h00;
   logic [7:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic EXT_IRQ_PIN = 1'b1;
   logic [3:0] PIN_CHANGE_INPUTS = 4'h0;
   logic GLOBAL_IRQ_ENABLE = 1'b0;
   pic_pkg::pic_periph_req_t PERIPH_REQ = '0;
   logic take = 1'b0;
   logic [3:0] delay = 4'h0;
   logic [7:0] RDATA, a, d;
   logic IRQ_ACK, IRQ_REQ, WAKE;
   logic [3:0] IRQ_VECTOR, RESET_VECTOR, served;
   integer seed = 32'hdec7bfdf;
   int num_errors = 0;
   int n_compared = 0;
   int cyc = 0;
   always #2.5 REF_CLK = ~REF_CLK;
   pic_top u_pic_top (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
      .RD(RD), .RDATA(RDATA), .EXT_IRQ_PIN(EXT_IRQ_PIN), .PIN_CHANGE_INPUTS(PIN_CHANGE_INPUTS),
      .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .PERIPH_REQ(PERIPH_REQ), .IRQ_ACK(IRQ_ACK),
      .IRQ_REQ(IRQ_REQ), .IRQ_VECTOR(IRQ_VECTOR), .RESET_VECTOR(RESET_VECTOR), .WAKE(WAKE));
   pic_core_model u_pic_core_model (.clk(REF_CLK), .rst(RST), .take(take), .delay(delay),
      .irq_req(IRQ_REQ), .irq_vector(IRQ_VECTOR), .irq_ack(IRQ_ACK), .served_vec(served));
   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : complete_run
   task automatic chk_d(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_d
   task automatic chk_v(input logic [3:0] g, input logic [3:0] e);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk_v
   // a write right after a write waits one edge so WR is never set twice at once
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      if (WR)
         @(posedge REF_CLK);
      ADDR <= ad;
      WDATA <= dt;
      WR <= 1'b1;
      @(posedge REF_CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [7:0] ad, input logic [7:0] e);
      ADDR <= ad;
      RD <= 1'b1;
      @(posedge REF_CLK);
      RD <= 1'b0;
      #1 chk_d(RDATA, e);
      @(posedge REF_CLK);
   endtask : rdc
   task automatic serve(input logic [3:0] e);
      delay <= 4'($random(seed) & 7);
      GLOBAL_IRQ_ENABLE <= 1'b1;
      take <= 1'b1;
      repeat (60)
      begin
         @(posedge REF_CLK);
         if (IRQ_ACK === 1'b1)
            break;
      end
      take <= 1'b0;
      GLOBAL_IRQ_ENABLE <= 1'b0;
      chk_v(served, e);
   endtask : serve
   function automatic logic [7:0] rexp(input logic [7:0] ad, input logic [7:0] dt);
      case (ad)
         8'h10: rexp = dt & 8'h0f;
         8'h12, 8'h13: rexp = dt & 8'h01;
         8'h15: rexp = dt & 8'h03;
         default: rexp = 8'h00;
      endcase
   endfunction : rexp
   function automatic logic [3:0] pvec(input logic [7:0] p);
      pvec = 4'h0;
      for (int j = 0; j < 8; j++)
         if (p[j])
            pvec = 4'(10 - j);
   endfunction : pvec
   always @(posedge REF_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         num_errors++;
         complete_run;
      end
   end
   initial
   begin
      repeat (4) @(posedge REF_CLK);
      RST <= 1'b0;
      @(posedge REF_CLK);
      for (int i = 0; i < 8; i++)
         rdc(8'h10 + 8'(i), 8'h00);
      for (int i = 0; i < 12; i++)
      begin
         a = 8'h10 + 8'($random(seed) & 7);
         d = 8'($random(seed));
         wr(a, d);
         rdc(a, rexp(a, d));
      end
      $display("done: registers");
      // mask off: edges still set the flag but never request
      for (int i = 2; i < 8; i++)
      begin
         wr(8'h15, 8'(i >> 1));
         EXT_IRQ_PIN <= ~i[0];
         repeat (4) @(posedge REF_CLK);
         wr(8'h14, 8'h01);
         EXT_IRQ_PIN <= i[0];
         repeat (4) @(posedge REF_CLK);
         rdc(8'h14, {7'h00, (i < 4) || (i[0] == (i >= 6))});
      end
      $display("done: edges");
      wr(8'h15, 8'h00);
      wr(8'h13, 8'h01);
      EXT_IRQ_PIN <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      chk_v({3'h0, WAKE}, 4'h1);
      rdc(8'h14, 8'h00);
      serve(4'h1);
      EXT_IRQ_PIN <= 1'b1;
      wr(8'h13, 8'h00);
      $display("done: level");
      wr(8'h10, 8'($random(seed) & 6) | 8'h01);
      wr(8'h12, 8'h01);
      PIN_CHANGE_INPUTS <= 4'h8;
      repeat (3) @(posedge REF_CLK);
      rdc(8'h11, 8'h00);
      PIN_CHANGE_INPUTS <= 4'h9;
      repeat (3) @(posedge REF_CLK);
      rdc(8'h11, 8'h01);
      serve(4'h2);
      rdc(8'h11, 8'h00);
      wr(8'h12, 8'h00);
      $display("done: pin change");
      for (int i = 0; i < 11; i++)
      begin
         d = (i < 8) ? 8'h80 >> i : 8'($random(seed)) | 8'h01;
         PERIPH_REQ <= pic_pkg::pic_periph_req_t'(d);
         serve(pvec(d));
         PERIPH_REQ <= '0;
         repeat (3) @(posedge REF_CLK);
      end
      $display("done: vectors");
      complete_run;
   end
endmodule : pic_top_tb
`default_nettype wire

/* verilog/pic_defs.svh */
// Purpose: constants for the pin interrupt controller
// Assumes: 8-bit register port, offsets as byte addresses
// Notes: definitions only
`ifndef PIC_DEFS_SVH
`define PIC_DEFS_SVH
`define PIC_OFF_PC_MASK 8'h10
`define PIC_OFF_PC_FLAG 8'h11
`define PIC_OFF_PC_CTRL 8'h12
`define PIC_OFF_EXT_MASK 8'h13
`define PIC_OFF_EXT_FLAG 8'h14
`define PIC_OFF_EXT_SENSE 8'h15
`define PIC_RST_REG 8'h00
`define PIC_PC_MASK_BITS 8'h0f
`define PIC_BIT0_MASK 8'h01
`define PIC_SENSE_MASK 8'h03
`define PIC_VEC_RESET 4'h0
`define PIC_VEC_EXT 4'h1
`define PIC_VEC_PC 4'h2
`define PIC_VEC_TCAP 4'h3
`define PIC_VEC_TOVF 4'h4
`define PIC_VEC_TCMPA 4'h5
`define PIC_VEC_TCMPB 4'h6
`define PIC_VEC_COMP 4'h7
`define PIC_VEC_WDOG 4'h8
`define PIC_VEC_SUPPLY 4'h9
`define PIC_VEC_ADC 4'ha
`endif

/* verilog/pic_edge_detect.sv */
// Purpose: sample the external pin and detect the selected edge
// Assumes: pin already synchronous to the clock
// Notes: edge events only exist while the clock runs
`include "pic_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pic_edge_detect
(
   input wire logic clk,
   input wire logic rst,
   input wire logic pin,
   input wire pic_pkg::pic_sense_t sense,
   output logic edge_hit
);
   logic prev_q;
   logic prev_d;
   logic hit_d;
   logic hit_q;
   always_comb
   begin
      prev_d = pin;
      unique case (sense)
         pic_pkg::PIC_SENSE_LOW: hit_d = 1'b0;
         pic_pkg::PIC_SENSE_ANY: hit_d = pin ^ prev_q;
         pic_pkg::PIC_SENSE_FALL: hit_d = prev_q & ~pin;
         pic_pkg::PIC_SENSE_RISE: hit_d = ~prev_q & pin;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         prev_q <= 1'b1;
         hit_q <= 1'b0;
      end
      else
      begin
         prev_q <= prev_d;
         hit_q <= hit_d;
      end
   end
   assign edge_hit = hit_q;
endmodule : pic_edge_detect
`default_nettype wire

/* verilog/pic_pkg.sv */
// Purpose: types for the pin interrupt controller
// Assumes: nothing
// Notes: sense codes match the two-bit control field
package pic_pkg;
   typedef enum logic [1:0]
   {
      PIC_SENSE_LOW = 2'h0,
      PIC_SENSE_ANY = 2'h1,
      PIC_SENSE_FALL = 2'h2,
      PIC_SENSE_RISE = 2'h3
   } pic_sense_t;
   typedef struct packed
   {
      logic timer_capture;
      logic timer_overflow;
      logic timer_compare_a;
      logic timer_compare_b;
      logic comparator;
      logic watchdog;
      logic supply_monitor;
      logic adc_complete;
   } pic_periph_req_t;
   typedef enum logic [2:0]
   {
      PIC_ST_IDLE = 3'h1,
      PIC_ST_REQ = 3'h2,
      PIC_ST_ACK = 3'h4
   } pic_state_t;
endpackage : pic_pkg

/* verilog/pic_top.sv */
// Purpose: external pin and pin-change interrupt controller with vector select
// Assumes: pins synchronous to REF_CLK; core sends one-cycle entry ack
// Notes: asynchronous wake paths are combinational outputs
`include "pic_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - reset vector at address zero
// - external pin request vectors to one
// - pin-change request vectors to two
// - peripheral sources follow at three through ten
// - pins trigger even when driven as outputs
// - any masked pin-change input toggle requests
// - pin-change wake works without clock
// - low level requests while pin low
// - edges recognised only with clock running
// - low level wake is asynchronous
// - vanished level wakes without interrupt
// - external needs global and mask enable
// - pin sampled, pulses over one clock caught
// - sense field codes low, any, fall, rise
// - triggering edge sets external flag
// - flags clear on entry or written one
// - flag reads zero in low-level mode
// - pin-change needs group and global enable
// - pin change sets flag bit zero
// - mask bits select contributing pins
// - reserved bits read zero
module pic_top
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic EXT_IRQ_PIN,
   input wire logic [3:0] PIN_CHANGE_INPUTS,
   input wire logic GLOBAL_IRQ_ENABLE,
   input wire pic_pkg::pic_periph_req_t PERIPH_REQ,
   input wire logic IRQ_ACK,
   output logic IRQ_REQ,
   output logic [3:0] IRQ_VECTOR,
   output logic [3:0] RESET_VECTOR,
   output logic WAKE
);
   logic [3:0] pc_mask_q;
   logic [3:0] pc_mask_d;
   logic pc_flag_q;
   logic pc_flag_d;
   logic pc_en_q;
   logic pc_en_d;
   logic ext_mask_q;
   logic ext_mask_d;
   logic ext_flag_q;
   logic ext_flag_d;
   logic [1:0] sense_q;
   logic [1:0] sense_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic [3:0] pc_prev_q;
   logic [3:0] pc_prev_d;
   logic [3:0] vec_q;
   logic [3:0] vec_d;
   pic_pkg::pic_state_t state_q;
   pic_pkg::pic_state_t state_d;
   logic edge_hit;
   logic level_low;
   logic pc_change;
   logic ext_pend;
   logic pc_pend;
   logic any_pend;
   logic [3:0] pick;
   pic_pkg::pic_sense_t sense_e;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // reserved and unmapped bits read zero, so software can mask nothing
   function automatic logic [7:0] rd_byte
   (
      input logic [7:0] a,
      input logic [3:0] msk,
      input logic pcf,
      input logic pce,
      input logic exm,
      input logic exf,
      input logic [1:0] sns
   );
      case (a)
         `PIC_OFF_PC_MASK: rd_byte = {4'h0, msk} & `PIC_PC_MASK_BITS;
         `PIC_OFF_PC_FLAG: rd_byte = {7'h00, pcf} & `PIC_BIT0_MASK;
         `PIC_OFF_PC_CTRL: rd_byte = {7'h00, pce} & `PIC_BIT0_MASK;
         `PIC_OFF_EXT_MASK: rd_byte = {7'h00, exm} & `PIC_BIT0_MASK;
         `PIC_OFF_EXT_FLAG: rd_byte = {7'h00, exf} & `PIC_BIT0_MASK;
         `PIC_OFF_EXT_SENSE: rd_byte = {6'h00, sns} & `PIC_SENSE_MASK;
         default: rd_byte = `PIC_RST_REG;
      endcase
   endfunction : rd_byte

   assign sense_e = pic_pkg::pic_sense_t'(sense_q);

   // pins are observed at the input buffer, independent of direction
   pic_edge_detect u_edge
   (
      .clk(REF_CLK),
      .rst(RST),
      .pin(EXT_IRQ_PIN),
      .sense(sense_e),
      .edge_hit(edge_hit)
   );

   assign level_low = (sense_e == pic_pkg::PIC_SENSE_LOW) & ~EXT_IRQ_PIN;
   // change compare is combinational so a stopped clock still sees toggles
   assign pc_change = |((PIN_CHANGE_INPUTS ^ pc_prev_q) & pc_mask_q);
   assign ext_pend = ext_mask_q & (ext_flag_q | level_low) & GLOBAL_IRQ_ENABLE;
   assign pc_pend = pc_en_q & pc_flag_q & GLOBAL_IRQ_ENABLE;

   // level vanishing before wake completes simply leaves no pending request
   assign WAKE = (ext_mask_q & level_low) | (pc_en_q & pc_change);

   always_comb
   begin
      pick = `PIC_VEC_RESET;
      any_pend = 1'b1;
      // fixed priority, lowest vector first
      if (ext_pend)
         pick = `PIC_VEC_EXT;
      else if (pc_pend)
         pick = `PIC_VEC_PC;
      else if (PERIPH_REQ.timer_capture)
         pick = `PIC_VEC_TCAP;
      else if (PERIPH_REQ.timer_overflow)
         pick = `PIC_VEC_TOVF;
      else if (PERIPH_REQ.timer_compare_a)
         pick = `PIC_VEC_TCMPA;
      else if (PERIPH_REQ.timer_compare_b)
         pick = `PIC_VEC_TCMPB;
      else if (PERIPH_REQ.comparator)
         pick = `PIC_VEC_COMP;
      else if (PERIPH_REQ.watchdog)
         pick = `PIC_VEC_WDOG;
      else if (PERIPH_REQ.supply_monitor)
         pick = `PIC_VEC_SUPPLY;
      else if (PERIPH_REQ.adc_complete)
         pick = `PIC_VEC_ADC;
      else
         any_pend = 1'b0;
   end

   always_comb
   begin
      state_d = state_q;
      vec_d = vec_q;
      unique case (state_q)
         pic_pkg::PIC_ST_IDLE:
         begin
            if (any_pend)
            begin
               state_d = pic_pkg::PIC_ST_REQ;
               vec_d = pick;
            end
         end
         pic_pkg::PIC_ST_REQ:
         begin
            if (IRQ_ACK)
               state_d = pic_pkg::PIC_ST_ACK;
            else if (!any_pend)
               state_d = pic_pkg::PIC_ST_IDLE;
            else
               vec_d = pick;
         end
         pic_pkg::PIC_ST_ACK:
            state_d = pic_pkg::PIC_ST_IDLE;
         default:
            state_d = pic_pkg::PIC_ST_IDLE;
      endcase
   end

   // configuration registers; unmapped writes fall through untouched
   always_comb
   begin
      pc_mask_d = pc_mask_q;
      pc_en_d = pc_en_q;
      ext_mask_d = ext_mask_q;
      sense_d = sense_q;
      if (WR)
      begin
         if (hit(ADDR, `PIC_OFF_PC_MASK))
            pc_mask_d = WDATA[3:0];
         if (hit(ADDR, `PIC_OFF_PC_CTRL))
            pc_en_d = WDATA[0];
         if (hit(ADDR, `PIC_OFF_EXT_MASK))
            ext_mask_d = WDATA[0];
         if (hit(ADDR, `PIC_OFF_EXT_SENSE))
            sense_d = WDATA[1:0];
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         pc_mask_q <= 4'h0;
         pc_en_q <= 1'b0;
         ext_mask_q <= 1'b0;
         sense_q <= 2'h0;
      end
      else
      begin
         pc_mask_q <= pc_mask_d;
         pc_en_q <= pc_en_d;
         ext_mask_q <= ext_mask_d;
         sense_q <= sense_d;
      end
   end

   // flags and the pin-change history
   always_comb
   begin
      pc_flag_d = pc_flag_q;
      ext_flag_d = ext_flag_q;
      pc_prev_d = PIN_CHANGE_INPUTS;
      if (WR && hit(ADDR, `PIC_OFF_PC_FLAG) && WDATA[0])
         pc_flag_d = 1'b0;
      if (WR && hit(ADDR, `PIC_OFF_EXT_FLAG) && WDATA[0])
         ext_flag_d = 1'b0;
      if (state_q == pic_pkg::PIC_ST_REQ && IRQ_ACK)
      begin
         if (vec_q == `PIC_VEC_EXT)
            ext_flag_d = 1'b0;
         if (vec_q == `PIC_VEC_PC)
            pc_flag_d = 1'b0;
      end
      // set after clear so a coincident event is kept
      if (pc_change)
         pc_flag_d = 1'b1;
      if (edge_hit)
         ext_flag_d = 1'b1;
      if (sense_e == pic_pkg::PIC_SENSE_LOW)
         ext_flag_d = 1'b0;
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         pc_flag_q <= 1'b0;
         ext_flag_q <= 1'b0;
         pc_prev_q <= 4'h0;
      end
      else
      begin
         pc_flag_q <= pc_flag_d;
         ext_flag_q <= ext_flag_d;
         pc_prev_q <= pc_prev_d;
      end
   end

   // read data stands for one cycle only, zero otherwise
   always_comb
   begin
      rdata_d = `PIC_RST_REG;
      if (RD)
         rdata_d = rd_byte(ADDR, pc_mask_q, pc_flag_q, pc_en_q, ext_mask_q, ext_flag_q,
            sense_q);
   end

   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         rdata_q <= `PIC_RST_REG;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // request state and the vector it presents
   always_ff @(posedge REF_CLK)
   begin
      if (RST)
      begin
         vec_q <= `PIC_VEC_RESET;
         state_q <= pic_pkg::PIC_ST_IDLE;
      end
      else
      begin
         vec_q <= vec_d;
         state_q <= state_d;
      end
   end

   assign RDATA = rdata_q;
   assign IRQ_REQ = (state_q == pic_pkg::PIC_ST_REQ);
   assign IRQ_VECTOR = vec_q;
   assign RESET_VECTOR = `PIC_VEC_RESET;
endmodule : pic_top
`default_nettype wire
